/* File: tal_alarm_properties.sv */
`timescale 1ns/10ps
module tal_alarm_properties (
  // clock and reset
  input logic        clock,
  input logic        rst_n,
  // register port
  input logic [7:0]  reg_addr,
  input logic        reg_rd,
  input logic [15:0] reg_rdata,
  input logic        reg_rvalid,
  // samples and control
  input logic        temp_valid,
  input logic        sensor_sleep,
  input logic        window_trip_lock,
  input logic        critical_trip_lock,
  // outputs
  input logic        alert_o,
  input logic        alert_oe,
  input logic        alert_status_flag,
  input logic        upper_trip_flag
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  property p_rd_ans; reg_rd |=> reg_rvalid; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  property p_no_spur; !reg_rd |=> !reg_rvalid; endproperty
  a_no_spur: assert property (p_no_spur) else $error("stray read valid");
  property p_cfg_rd;
    reg_rd && reg_addr == 8'h01 |=> reg_rdata[4] == $past(alert_status_flag)
      && reg_rdata[8] == $past(sensor_sleep) && reg_rdata[6] == $past(window_trip_lock)
      && reg_rdata[7] == $past(critical_trip_lock) && !reg_rdata[5];
  endproperty
  a_cfg_rd: assert property (p_cfg_rd) else $error("config readback wrong");
  property p_hole; reg_rd && (reg_addr == 8'h00 || reg_addr > 8'h03) |=> reg_rdata == 16'h0000;
  endproperty
  a_hole: assert property (p_hole) else $error("unmapped read not zero");
  property p_rsv; reg_rd && reg_addr[7:1] == 7'h01 |=> (reg_rdata & 16'he003) == 16'h0000;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved trip bits set");
  property p_sleep_sts; sensor_sleep |=> !alert_status_flag; endproperty
  a_sleep_sts: assert property (p_sleep_sts) else $error("status kept in sleep");
  property p_sleep_pin; sensor_sleep |=> !alert_oe; endproperty
  a_sleep_pin: assert property (p_sleep_pin) else $error("pin driven in sleep");
  property p_freeze; sensor_sleep && temp_valid |=> $stable(upper_trip_flag); endproperty
  a_freeze: assert property (p_freeze) else $error("flag moved in sleep");
  // a high pin level can only mean an asserted alert in active-high polarity
  property p_pin_sts; alert_o |-> alert_status_flag; endproperty
  a_pin_sts: assert property (p_pin_sts) else $error("pin high without alert");
  property p_sts_drv; alert_status_flag |-> alert_oe; endproperty
  a_sts_drv: assert property (p_sts_drv) else $error("alert not driven");
  c_high: cover property (alert_status_flag && alert_o);
  c_sleep: cover property (sensor_sleep && temp_valid);
  c_clear: cover property ($fell(alert_status_flag) && !sensor_sleep);
endmodule

/* File: tal_alarm_top.v */
`timescale 1ns/10ps
`include "tal_map.vh"

module tal_alarm_top (
  // clock and reset
  input  wire        clock,
  input  wire        rst_n,
  // register port from the serial front end
  input  wire [7:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [15:0] reg_rdata,
  output reg         reg_rvalid,
  // converter samples, signed 0.125 degree steps
  input  wire [11:0] temp_code,
  input  wire        temp_valid,
  // neighbouring configuration and critical trip logic
  input  wire [15:0] critical_trip_value,
  input  wire [1:0]  hysteresis_select,
  input  wire        critical_trip_lock,
  input  wire        window_trip_lock,
  input  wire        sensor_sleep,
  // alert pin
  output wire        alert_o,
  output wire        alert_oe,
  // status
  output wire        alert_status_flag,
  output wire        upper_trip_flag,
  output wire        lower_trip_flag,
  output wire        critical_trip_flag
);

  ////////////////////////////////////////////////////////////////////////
  // helpers

  function [13:0] hyst_steps;
    input [1:0] sel;
    begin
      case (sel)
        2'b00:   hyst_steps = `TAL_HYST_NONE;
        2'b01:   hyst_steps = `TAL_HYST_1P5;
        2'b10:   hyst_steps = `TAL_HYST_3P0;
        2'b11:   hyst_steps = `TAL_HYST_6P0;
        default: hyst_steps = `TAL_HYST_NONE;
      endcase
    end
  endfunction

  // trip register to signed 0.125 degree steps; bit 12 carries the sign
  function [13:0] trip_to_steps;
    input [15:0] trip;
    begin
      trip_to_steps = {trip[`TAL_TRIP_SIGN], trip[`TAL_TRIP_SIGN],
                       trip[`TAL_TRIP_MSB:`TAL_TRIP_LSB], 1'b0};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // register state

  reg  [15:0] upper_trip_value;
  reg  [15:0] lower_trip_value;
  reg         alert_mode_select;
  reg         alert_polarity;
  reg         critical_only_select;
  reg         alert_output_enable;
  reg         alert_release;

  wire any_lock     = critical_trip_lock | window_trip_lock;
  wire wr_config    = reg_wr && (reg_addr == `TAL_ADDR_CONFIG);
  wire wr_upper     = reg_wr && (reg_addr == `TAL_ADDR_UPPER);
  wire wr_lower     = reg_wr && (reg_addr == `TAL_ADDR_LOWER);

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      upper_trip_value <= `TAL_TRIP_RESET;
      lower_trip_value <= `TAL_TRIP_RESET;
    end else begin
      if (wr_upper && !window_trip_lock)
        upper_trip_value <= reg_wdata & `TAL_TRIP_MASK;
      if (wr_lower && !window_trip_lock)
        lower_trip_value <= reg_wdata & `TAL_TRIP_MASK;
    end
  end

  // the status bit in a config write is read-only and dropped here
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      alert_mode_select    <= 1'b0;
      alert_polarity       <= 1'b0;
      critical_only_select <= 1'b0;
      alert_output_enable  <= 1'b0;
      alert_release        <= 1'b0;
    end else begin
      // self-clearing: a one-cycle pulse per release write while interrupt mode is already selected, never read back
      alert_release <= wr_config && reg_wdata[`TAL_CFG_REL] &&
                       alert_mode_select;
      if (wr_config && !any_lock) begin
        alert_mode_select   <= reg_wdata[`TAL_CFG_MODE];
        alert_polarity      <= reg_wdata[`TAL_CFG_POL];
        alert_output_enable <= reg_wdata[`TAL_CFG_OEN];
      end
      if (wr_config && !window_trip_lock)
        critical_only_select <= reg_wdata[`TAL_CFG_CRIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read back, one cycle after the strobe

  wire [15:0] config_view;
  assign config_view = {5'h00,
                        hysteresis_select,
                        sensor_sleep,
                        critical_trip_lock,
                        window_trip_lock,
                        1'b0,
                        alert_status_flag,
                        alert_output_enable,
                        critical_only_select,
                        alert_polarity,
                        alert_mode_select};

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata  <= 16'h0000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        case (reg_addr)
          `TAL_ADDR_CONFIG: reg_rdata <= config_view;
          `TAL_ADDR_UPPER:  reg_rdata <= upper_trip_value;
          `TAL_ADDR_LOWER:  reg_rdata <= lower_trip_value;
          default:          reg_rdata <= 16'h0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // comparison

  wire [13:0] temp_steps = {temp_code[11], temp_code[11], temp_code};
  wire [13:0] hyst_val   = hyst_steps(hysteresis_select);
  // no new samples are taken while asleep
  wire        sample_upd = temp_valid & ~sensor_sleep;
  wire [41:0] thresh_bus;
  wire [2:0]  trip_bus;

  assign thresh_bus = {trip_to_steps(critical_trip_value),
                       trip_to_steps(lower_trip_value),
                       trip_to_steps(upper_trip_value)};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_cmp
      tal_trip_cmp #(
        .HIGH_SIDE (gi == 1 ? 0 : 1)
      ) u_cmp (
        .clock      (clock),
        .rst_n      (rst_n),
        .temp_val   (temp_steps),
        .thresh_val (thresh_bus[gi*14 +: 14]),
        .hyst_val   (hyst_val),
        .update     (sample_upd),
        .trip_flag  (trip_bus[gi])
      );
    end
  endgenerate

  assign upper_trip_flag    = trip_bus[0];
  assign lower_trip_flag    = trip_bus[1];
  assign critical_trip_flag = trip_bus[2];

  ////////////////////////////////////////////////////////////////////////
  // alert output

  // setting critical-only together with the enable works here in one
  // write, but the host should still split them for portability
  wire alarm_src = critical_only_select ? critical_trip_flag
                                        : (|trip_bus);

  tal_alert_out u_alert (
    .clock         (clock),
    .rst_n         (rst_n),
    .alarm_src     (alarm_src),
    .output_enable (alert_output_enable),
    .polarity      (alert_polarity),
    .mode          (alert_mode_select),
    .release_req   (alert_release),
    .sleep         (sensor_sleep),
    .alert_o       (alert_o),
    .alert_oe      (alert_oe),
    .status        (alert_status_flag)
  );

endmodule

/* File: tal_alarm_top_test.sv */
`timescale 1ns/10ps
module tal_alarm_top_test;
  logic clock, rst_n, reg_wr, reg_rd, reg_rvalid, temp_valid, critical_trip_lock;
  logic window_trip_lock, sensor_sleep, alert_o, alert_oe, alert_status_flag;
  logic upper_trip_flag, lower_trip_flag, critical_trip_flag;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, critical_trip_value;
  logic [11:0] temp_code;
  logic [1:0] hysteresis_select;
  int errors, checks, cycles;
  tal_alarm_top tal_alarm_top_i (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .temp_code(temp_code), .temp_valid(temp_valid),
    .critical_trip_value(critical_trip_value), .hysteresis_select(hysteresis_select),
    .critical_trip_lock(critical_trip_lock), .window_trip_lock(window_trip_lock),
    .sensor_sleep(sensor_sleep), .alert_o(alert_o), .alert_oe(alert_oe),
    .alert_status_flag(alert_status_flag), .upper_trip_flag(upper_trip_flag),
    .lower_trip_flag(lower_trip_flag), .critical_trip_flag(critical_trip_flag));
  tal_host_model tal_host_model_i (.clock(clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  always #50 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      $display("wrong value at %0t: run timed out", $time);
      stop_test;
    end
  end
  ////////////////////////////////////////
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task rchk(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] d;
    tal_host_model_i.rd(a, d);
    chk(d, exp);
    chk({15'h0000, reg_rvalid}, 16'h0001);
  endtask
  // pin view: drive enable, level, status
  task pchk(input logic [2:0] e);
    chk({13'h0000, alert_oe, alert_o, alert_status_flag}, {13'h0000, e});
  endtask
  task samp(input logic [11:0] t);
    @(posedge clock);
    #1;
    temp_code = t;
    temp_valid = 1'b1;
    @(posedge clock);
    #1;
    temp_valid = 1'b0;
    temp_code = ~t;
    repeat (3) @(posedge clock);
    #1;
  endtask
  task stop_test;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////
  task t_reset;
    rchk(8'h01, 16'h0000);
    rchk(8'h02, 16'h0000);
    rchk(8'h03, 16'h0000);
    pchk(3'b000);
  endtask
  task t_regs;
    tal_host_model_i.wr(8'h02, 16'hffff);
    rchk(8'h02, 16'h1ffc);
    tal_host_model_i.wr(8'h03, 16'hf000);
    rchk(8'h03, 16'h1000);
    tal_host_model_i.wr(8'h07, 16'h0001);
    rchk(8'h07, 16'h0000);
  endtask
  // upper trip 21.25 degrees, 1.5 degree hysteresis
  task t_upper;
    hysteresis_select = 2'b01;
    tal_host_model_i.wr(8'h02, 16'h0154);
    tal_host_model_i.wr(8'h01, 16'h0008);
    rchk(8'h01, 16'h0208);
    samp(12'h0ab);
    pchk(3'b101);
    samp(12'h0a0);
    pchk(3'b101);
    samp(12'h09e);
    pchk(3'b000);
    hysteresis_select = 2'b10;
    samp(12'h0ab);
    samp(12'h093);
    pchk(3'b101);
    samp(12'h092);
    pchk(3'b000);
    hysteresis_select = 2'b11;
    samp(12'h0ab);
    samp(12'h07b);
    pchk(3'b101);
    samp(12'h07a);
    pchk(3'b000);
    hysteresis_select = 2'b01;
  endtask
  task t_lower;
    tal_host_model_i.wr(8'h03, 16'h0050);
    samp(12'h01b);
    chk({15'h0000, lower_trip_flag}, 16'h0001);
    pchk(3'b101);
    samp(12'h027);
    pchk(3'b101);
    samp(12'h028);
    pchk(3'b000);
  endtask
  task t_mode;
    tal_host_model_i.wr(8'h01, 16'h000b);
    samp(12'h0ab);
    pchk(3'b111);
    samp(12'h064);
    pchk(3'b111);
    tal_host_model_i.wr(8'h01, 16'h002b);
    // the release pulse is registered on the write edge and clears the status one edge later
    repeat (2) @(posedge clock);
    #1;
    pchk(3'b100);
    tal_host_model_i.wr(8'h01, 16'h0008);
    samp(12'h0ab);
    tal_host_model_i.wr(8'h01, 16'h0028);
    repeat (2) @(posedge clock);
    #1;
    pchk(3'b101);
  endtask
  task t_crit;
    tal_host_model_i.wr(8'h01, 16'h0004);
    tal_host_model_i.wr(8'h01, 16'h000c);
    samp(12'h0ab);
    pchk(3'b000);
    chk({15'h0000, critical_trip_flag}, 16'h0000);
    samp(12'h258);
    pchk(3'b101);
    chk({15'h0000, critical_trip_flag}, 16'h0001);
  endtask
  task t_lock;
    window_trip_lock = 1'b1;
    tal_host_model_i.wr(8'h02, 16'h0000);
    rchk(8'h02, 16'h0154);
    tal_host_model_i.wr(8'h03, 16'h0000);
    rchk(8'h03, 16'h0050);
    tal_host_model_i.wr(8'h01, 16'h0003);
    rchk(8'h01, 16'h025c);
    window_trip_lock = 1'b0;
    critical_trip_lock = 1'b1;
    tal_host_model_i.wr(8'h01, 16'h0003);
    rchk(8'h01, 16'h0298);
    critical_trip_lock = 1'b0;
  endtask
  task t_sleep;
    sensor_sleep = 1'b1;
    samp(12'h064);
    pchk(3'b000);
    chk({15'h0000, upper_trip_flag}, 16'h0001);
    sensor_sleep = 1'b0;
    repeat (3) @(posedge clock);
    #1;
    pchk(3'b101);
  endtask
  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    temp_code = 12'h000;
    temp_valid = 1'b0;
    critical_trip_value = 16'h0400;
    hysteresis_select = 2'b00;
    critical_trip_lock = 1'b0;
    window_trip_lock = 1'b0;
    sensor_sleep = 1'b0;
    repeat (12) @(posedge clock);
    #1;
    rst_n = 1'b1;
    t_reset;
    t_regs;
    t_upper;
    t_lower;
    t_mode;
    t_crit;
    t_lock;
    t_sleep;
    stop_test;
  end
endmodule
bind tal_alarm_top tal_alarm_properties tal_alarm_properties_i (.*);

/* File: tal_alert_out.v */
`timescale 1ns/10ps

// alert pin driver: gating, comparator or interrupt mode, polarity
module tal_alert_out (
  // clock and reset
  input  wire clock,
  input  wire rst_n,
  // control
  input  wire alarm_src,
  input  wire output_enable,
  input  wire polarity,
  input  wire mode,
  input  wire release_req,
  input  wire sleep,
  // pin and status
  output reg  alert_o,
  output reg  alert_oe,
  output reg  status
);

  reg src_prev_reg;
  reg pend_reg;
  reg pend_next;
  reg active_next;
  wire src_rise = alarm_src & ~src_prev_reg;

  always @* begin
    pend_next = pend_reg;
    if (sleep || !mode || !output_enable)
      pend_next = 1'b0;
    else if (src_rise)
      pend_next = 1'b1;
    else if (release_req)
      pend_next = 1'b0;
    if (sleep)
      active_next = 1'b0;
    else if (!output_enable)
      active_next = 1'b0;
    else if (mode)
      active_next = pend_next;
    else
      active_next = alarm_src;
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      src_prev_reg <= 1'b0;
      pend_reg     <= 1'b0;
      status       <= 1'b0;
      alert_o      <= 1'b0;
      alert_oe     <= 1'b0;
    end else begin
      src_prev_reg <= alarm_src;
      pend_reg     <= pend_next;
      status       <= active_next;
      // active low is open drain: drive 0 only while asserted
      alert_o      <= polarity ? active_next : 1'b0;
      alert_oe     <= polarity ? ~sleep : (active_next & ~sleep);
    end
  end

endmodule

/* File: tal_host_model.sv */
`timescale 1ns/10ps
module tal_host_model (
  // clock
  input  logic        clock,
  // register port
  output logic [7:0]  reg_addr,
  output logic [15:0] reg_wdata,
  output logic        reg_wr,
  output logic        reg_rd,
  input  logic [15:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  ////////////////////////////////////////
  // data is scrambled after the write so a stale bus value cannot pass
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clock);
    #1;
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
  task rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clock);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clock);
    #1;
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask
endmodule

/* File: tal_map.vh */
`ifndef TAL_MAP_VH
`define TAL_MAP_VH

// register addresses on the internal register port
`define TAL_ADDR_CONFIG     8'h01
`define TAL_ADDR_UPPER      8'h02
`define TAL_ADDR_LOWER      8'h03

// trip registers: sign in bit 12, value in 11:2, the rest reads zero
`define TAL_TRIP_MASK       16'h1ffc
`define TAL_TRIP_RESET      16'h0000
`define TAL_TRIP_SIGN       12
`define TAL_TRIP_MSB        12
`define TAL_TRIP_LSB        2

// configuration field positions
`define TAL_CFG_MODE        0
`define TAL_CFG_POL         1
`define TAL_CFG_CRIT        2
`define TAL_CFG_OEN         3
`define TAL_CFG_STS         4
`define TAL_CFG_REL         5
`define TAL_CFG_WLOCK       6
`define TAL_CFG_CLOCK       7
`define TAL_CFG_SLEEP       8
`define TAL_CFG_HYST_LSB    9
`define TAL_CFG_HYST_MSB    10
`define TAL_CFG_RESET       4'h0

// hysteresis in 0.125 degree steps
`define TAL_HYST_NONE       14'h0000
`define TAL_HYST_1P5        14'h000c
`define TAL_HYST_3P0        14'h0018
`define TAL_HYST_6P0        14'h0030

`endif

/* File: tal_trip_cmp.v */
`timescale 1ns/10ps
`include "tal_map.vh"

// one trip boundary with hysteresis on falling temperature
module tal_trip_cmp #(
  parameter HIGH_SIDE = 1
) (
  // clock and reset
  input  wire        clock,
  input  wire        rst_n,
  // compare values in signed 0.125 degree steps, plus the sample update strobe
  input  wire [13:0] temp_val,
  input  wire [13:0] thresh_val,
  input  wire [13:0] hyst_val,
  input  wire        update,
  // trip flag
  output reg         trip_flag
);

  wire signed [13:0] t_s  = temp_val;
  wire signed [13:0] th_s = thresh_val;
  wire signed [13:0] lo_s = thresh_val - hyst_val;
  reg                trip_next;

  always @* begin
    trip_next = trip_flag;
    if (HIGH_SIDE != 0) begin
      if (t_s > th_s)
        trip_next = 1'b1;
      else if (t_s <= lo_s)
        trip_next = 1'b0;
    end else begin
      if (t_s < lo_s)
        trip_next = 1'b1;
      else if (t_s >= th_s)
        trip_next = 1'b0;
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n)
      trip_flag <= 1'b0;
    else if (update)
      trip_flag <= trip_next;
  end

endmodule
